// File: hw/agu_consts.svh
// offsets, field positions and reset values of the address unit
`ifndef AGU_CONSTS_SVH
`define AGU_CONSTS_SVH
`define ADDR_MODCFG 4'h0
`define ADDR_BITREV 4'h1
`define ADDR_TABLE_PAGE 4'h2
`define ADDR_LASTEA 4'h3
`define RST_MODCFG 16'h0F00
`define RST_BITREV 16'h0000
`define RST_TABLE_PAGE 8'h00
`define SEL_HI 11
`define SEL_LO 8
`define SEL_NONE 4'hF
`define BITREV_ENABLE_BIT 15
`define PIVOT_HI 14
`define CFG_BIT 7
`define READ_LAT 2
`endif

// File: hw/agu_pkg.sv
// types of the address unit
package agu_pkg;
	typedef enum logic [1:0] {MODE_PLAIN = 2'b00, MODE_PRE_INC = 2'b01,
		MODE_POST_INC = 2'b10, MODE_INDEXED = 2'b11} ind_mode_t;
	typedef enum logic [1:0] {PS_FETCH = 2'b00, PS_TABLE_RD = 2'b01,
		PS_TABLE_WR = 2'b10, PS_WINDOW_RD = 2'b11} ps_kind_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic word;
		ind_mode_t mode;
		logic [3:0] ptr_sel;
		logic [15:0] ptr;
		logic [15:0] offset;
		logic modulo_on;
		logic [15:0] modulo_ea;
	} data_req_t;
	typedef struct packed {
		logic valid;
		logic bitrev;
		logic [15:0] ea;
	} data_ans_t;
	typedef struct packed {
		logic valid;
		ps_kind_t kind;
		logic high;
		logic word;
		logic [22:0] pc;
		logic [15:0] ea;
		logic [15:0] wdata;
	} ps_req_t;
	typedef struct packed {
		logic rd;
		logic wr;
		logic config_space;
		logic [23:0] addr;
		logic [2:0] lanes;
		logic [23:0] wdata;
	} ps_cmd_t;
	typedef struct packed {
		logic valid;
		logic high;
		logic word;
		logic bsel;
	} pend_t;
	typedef struct packed {
		logic [15:0] modcfg;
		logic [15:0] bitrev;
		logic [7:0] table_page;
		logic [15:0] rdata;
		data_ans_t dans;
		ps_cmd_t pcmd;
		pend_t pend;
		pend_t pend_d;
		logic rd_valid;
		logic [15:0] rd_data;
	} state_t;
endpackage

// File: hw/bitrev_and_progspace_agu.sv
// bit-reversed data addressing and program-space address construction
`timescale 1ns/1ps
`include "agu_consts.svh"

// Operation
// - Reversal needs pointer select not 1111, enable set and pre/post increment.
// - The 15-bit pivot field is the bit-reversed modifier, usually half the buffer size.
// - Reversed addresses are word addresses, pivot scaled to bytes, LSb always zero.
// - Only word writes with pre- or post-increment get reversal, all else gets normal addresses.
// - Active reversal joins pointer and pivot, ignoring mode offset and LSb.
// - Bit reversal wins over modulo addressing for data writes on the same pointer.
// - A sixteen-entry buffer walks address bits four to one in reversed order.
// - Program space is 24 bits wide, data space 16 bits, with alignment kept.
// - Table addresses are the table page on bits 23 to 16 joined with data address bits 15 to 1 and a zero LSb.
// - Table accesses reach every byte of a program word, the upper byte included.
// - The program window in data space is read-only and yields only the low word.
// - Fetch addresses have bit 23 zero, bits 22 to 1 from the program counter and bit 0 zero.
// - Program-space addresses always have their LSb at zero.
// - Table operations need no word alignment and reads may reach configuration space.
// - Table page bit 7 zero selects user memory, one selects configuration space for table reads and writes; window reads always stay in user memory.
module bitrev_and_progspace_agu (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input agu_pkg::data_req_t data_req,
	output agu_pkg::data_ans_t data_ans,
	input agu_pkg::ps_req_t ps_req,
	output agu_pkg::ps_cmd_t ps_cmd,
	input wire logic [23:0] prog_rdata,
	output logic ps_rd_valid,
	output logic [15:0] ps_rd_data
);
	agu_pkg::state_t st_reg;
	agu_pkg::state_t st_next;
	logic [15:0] base_w;
	logic [15:0] pivot_b;
	logic [15:0] rev_w;
	logic [15:0] rev_p;
	logic [15:0] rev_sum;
	logic [15:0] sum;
	logic [15:0] br_ea;
	logic br_on;

	// ************************************
	// reverse-carry add of pointer and pivot
	// ************************************
	assign base_w = {data_req.ptr[15:1], 1'b0};
	assign pivot_b = {st_reg.bitrev[`PIVOT_HI:0], 1'b0};
	genvar i;
	generate
		for (i = 0; i < 16; i = i + 1)
		begin : g_rev
			assign rev_w[i] = base_w[15 - i];
			assign rev_p[i] = pivot_b[15 - i];
			assign sum[i] = rev_sum[15 - i];
		end
	endgenerate
	assign rev_sum = rev_w + rev_p;
	assign br_ea = {sum[15:1], 1'b0};
	assign br_on = (st_reg.modcfg[`SEL_HI:`SEL_LO] != `SEL_NONE)
		&& st_reg.bitrev[`BITREV_ENABLE_BIT]
		&& (data_req.mode == agu_pkg::MODE_PRE_INC
		|| data_req.mode == agu_pkg::MODE_POST_INC)
		&& (data_req.ptr_sel == st_reg.modcfg[`SEL_HI:`SEL_LO])
		&& data_req.write && data_req.word;

	// ************************************
	// next state
	// ************************************
	always_comb
	begin
		st_next = st_reg;
		st_next.rdata = 16'h0000;
		// register port
		if (reg_wr)
		begin
			if (reg_addr == `ADDR_MODCFG)
			begin
				st_next.modcfg = reg_wdata;
			end
			else if (reg_addr == `ADDR_BITREV)
			begin
				st_next.bitrev = reg_wdata;
			end
			else if (reg_addr == `ADDR_TABLE_PAGE)
			begin
				st_next.table_page = reg_wdata[7:0];
			end
		end
		if (reg_rd)
		begin
			if (reg_addr == `ADDR_MODCFG)
			begin
				st_next.rdata = st_reg.modcfg;
			end
			else if (reg_addr == `ADDR_BITREV)
			begin
				st_next.rdata = st_reg.bitrev;
			end
			else if (reg_addr == `ADDR_TABLE_PAGE)
			begin
				st_next.rdata = {8'h00, st_reg.table_page};
			end
			else if (reg_addr == `ADDR_LASTEA)
			begin
				st_next.rdata = st_reg.dans.ea;
			end
		end
		// data address
		st_next.dans.valid = data_req.valid;
		st_next.dans.bitrev = data_req.valid && br_on;
		if (data_req.valid)
		begin
			if (br_on)
			begin
				st_next.dans.ea = br_ea;
			end
			else if (data_req.modulo_on)
			begin
				st_next.dans.ea = data_req.modulo_ea;
			end
			else if (data_req.mode == agu_pkg::MODE_PRE_INC
				|| data_req.mode == agu_pkg::MODE_INDEXED)
			begin
				st_next.dans.ea = data_req.ptr + data_req.offset;
			end
			else
			begin
				st_next.dans.ea = data_req.ptr;
			end
		end
		// program space
		st_next.pcmd.rd = 1'b0;
		st_next.pcmd.wr = 1'b0;
		st_next.pcmd.lanes = 3'b000;
		st_next.pend = '0;
		if (ps_req.valid)
		begin
			case (ps_req.kind)
				agu_pkg::PS_FETCH:
				begin
					st_next.pcmd.rd = 1'b1;
					st_next.pcmd.config_space = 1'b0;
					st_next.pcmd.addr = {1'b0, ps_req.pc[22:1], 1'b0};
					st_next.pcmd.lanes = 3'b111;
				end
				agu_pkg::PS_TABLE_RD, agu_pkg::PS_TABLE_WR:
				begin
					st_next.pcmd.rd = (ps_req.kind == agu_pkg::PS_TABLE_RD);
					st_next.pcmd.wr = (ps_req.kind == agu_pkg::PS_TABLE_WR);
					st_next.pcmd.config_space = st_reg.table_page[`CFG_BIT];
					st_next.pcmd.addr = {st_reg.table_page, ps_req.ea[15:1], 1'b0};
					st_next.pend.valid = (ps_req.kind == agu_pkg::PS_TABLE_RD);
					st_next.pend.high = ps_req.high;
					st_next.pend.word = ps_req.word;
					st_next.pend.bsel = ps_req.ea[0];
					if (ps_req.high)
					begin
						// phantom byte takes no lane
						st_next.pcmd.lanes = (ps_req.word || !ps_req.ea[0]) ? 3'b100 : 3'b000;
						st_next.pcmd.wdata = {ps_req.wdata[7:0], 16'h0000};
					end
					else
					begin
						st_next.pcmd.lanes = ps_req.word ? 3'b011
							: (ps_req.ea[0] ? 3'b010 : 3'b001);
						st_next.pcmd.wdata = ps_req.word ? {8'h00, ps_req.wdata}
							: {8'h00, ps_req.wdata[7:0], ps_req.wdata[7:0]};
					end
				end
				agu_pkg::PS_WINDOW_RD:
				begin
					st_next.pcmd.rd = 1'b1;
					st_next.pcmd.config_space = 1'b0;
					st_next.pcmd.addr = {st_reg.table_page, ps_req.ea[15:1], 1'b0};
					st_next.pcmd.lanes = 3'b011;
					st_next.pend.valid = 1'b1;
					st_next.pend.high = 1'b0;
					st_next.pend.word = 1'b1;
					st_next.pend.bsel = 1'b0;
				end
				default:
				begin
					st_next.pcmd.rd = 1'b0;
				end
			endcase
		end
		// read return, one cycle after the memory answers
		st_next.pend_d = st_reg.pend;
		st_next.rd_valid = st_reg.pend_d.valid;
		if (st_reg.pend_d.valid)
		begin
			if (st_reg.pend_d.high)
			begin
				st_next.rd_data = (st_reg.pend_d.word || !st_reg.pend_d.bsel)
					? {8'h00, prog_rdata[23:16]} : 16'h0000;
			end
			else if (st_reg.pend_d.word)
			begin
				st_next.rd_data = prog_rdata[15:0];
			end
			else
			begin
				st_next.rd_data = {8'h00, st_reg.pend_d.bsel ? prog_rdata[15:8]
					: prog_rdata[7:0]};
			end
		end
	end

	// ************************************
	// state register
	// ************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= '0;
			st_reg.modcfg <= `RST_MODCFG;
			st_reg.bitrev <= `RST_BITREV;
			st_reg.table_page <= `RST_TABLE_PAGE;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign data_ans = st_reg.dans;
	assign ps_cmd = st_reg.pcmd;
	assign ps_rd_valid = st_reg.rd_valid;
	assign ps_rd_data = st_reg.rd_data;

	// ************************************
	// checks
	// ************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_stack_never_rev: assert property (
		data_ans.bitrev |-> $past(st_reg.modcfg[`SEL_HI:`SEL_LO]) != 4'hF
		&& $past(st_reg.bitrev[15]))
		else $error("bit reversal with pointer select disabled");
	a_rev_lsb_clear: assert property (
		data_ans.bitrev |-> data_ans.ea[0] == 1'b0)
		else $error("bit-reversed address has LSb set");
	a_rev_word_write: assert property (
		data_ans.bitrev |-> $past(data_req.write) && $past(data_req.word))
		else $error("bit reversal on byte or read access");
	a_rev_priority: assert property (
		data_req.valid && br_on |=> data_ans.bitrev && data_ans.ea == $past(br_ea))
		else $error("bit reversal lost priority");
	a_fetch_addr: assert property (
		ps_req.valid && ps_req.kind == agu_pkg::PS_FETCH
		|=> ps_cmd.rd && ps_cmd.addr == {1'b0, $past(ps_req.pc[22:1]), 1'b0})
		else $error("fetch address wrong");
	a_table_page: assert property (
		ps_req.valid && ps_req.kind == agu_pkg::PS_TABLE_WR
		|=> ps_cmd.wr && ps_cmd.addr[23:16] == $past(st_reg.table_page))
		else $error("table page not on upper address");
	a_prog_lsb_zero: assert property (
		(ps_cmd.rd || ps_cmd.wr) |-> ps_cmd.addr[0] == 1'b0)
		else $error("program address LSb set");
	a_window_read_only: assert property (
		ps_req.valid && ps_req.kind == agu_pkg::PS_WINDOW_RD |=> !ps_cmd.wr)
		else $error("window access wrote program memory");
	a_config_select: assert property (
		ps_req.valid && ps_req.kind == agu_pkg::PS_TABLE_RD
		|=> ps_cmd.config_space == $past(st_reg.table_page[7]))
		else $error("config space select wrong");
	a_read_return: assert property (
		ps_req.valid && ps_req.kind == agu_pkg::PS_TABLE_RD && ps_req.high
		&& ps_req.word |=> ##2 ps_rd_valid
		&& ps_rd_data == {8'h00, $past(prog_rdata[23:16])})
		else $error("upper byte read not returned");
endmodule

// File: verif/prog_mem_model.sv
// program memory model facing the address unit
`timescale 1ns/1ps
module prog_mem_model (
	input wire logic clk,
	input wire logic rst_n,
	input agu_pkg::ps_cmd_t ps_cmd,
	output logic [23:0] prog_rdata
);
	// ****
	// read return, toggling when not asked
	// ****
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prog_rdata <= 24'h00_0000;
		else if (ps_cmd.rd)
			prog_rdata <= {ps_cmd.addr[7:0], ps_cmd.addr[15:0]} ^ 24'h5A_C3E1;
		else
			prog_rdata <= ~prog_rdata;
	end
endmodule

// File: verif/tb_top.sv
// self-checking bench of the address unit
`timescale 1ns/1ps
`include "agu_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin err_total++; \
	$display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	agu_pkg::data_req_t data_req = '0;
	agu_pkg::data_ans_t data_ans;
	agu_pkg::ps_req_t ps_req = '0;
	agu_pkg::ps_cmd_t ps_cmd;
	logic [23:0] prog_rdata;
	logic ps_rd_valid;
	logic [15:0] ps_rd_data;
	logic rd_seen = 1'b0;
	logic [15:0] q_reg[$];
	logic [16:0] q_dat[$];
	logic [29:0] q_cmd[$];
	logic [15:0] q_ret[$];
	logic [23:0] q_wd[$];
	logic [23:0] e_wd;
	logic [16:0] g_dat;
	logic [29:0] g_cmd;
	logic [15:0] e_reg, e_ret, cfg, brc, last_ea, pt;
	logic [16:0] e_dat;
	logic [29:0] e_cmd;
	logic [7:0] pg;
	int err_total = 0;
	int n_checks = 0;
	always #25 clk = ~clk;
	bitrev_and_progspace_agu bitrev_and_progspace_agu_inst (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .data_req(data_req), .data_ans(data_ans), .ps_req(ps_req),
		.ps_cmd(ps_cmd), .prog_rdata(prog_rdata), .ps_rd_valid(ps_rd_valid),
		.ps_rd_data(ps_rd_data));
	prog_mem_model prog_mem_model_inst (.clk(clk), .rst_n(rst_n), .ps_cmd(ps_cmd),
		.prog_rdata(prog_rdata));
	// ****
	// helpers and drivers
	// ****
	function automatic logic [15:0] rv(input logic [15:0] v);
		for (int i = 0; i < 16; i++)
			rv[i] = v[15 - i];
	endfunction
	task automatic reg_op(input logic w, input logic [3:0] a, input logic [15:0] d,
		input logic [15:0] e);
		if (w && a == `ADDR_MODCFG) cfg = d;
		if (w && a == `ADDR_BITREV) brc = d;
		if (w && a == `ADDR_TABLE_PAGE) pg = d[7:0];
		if (!w) q_reg.push_back(e);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge clk);
	endtask
	task automatic idle();
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		data_req.valid <= 1'b0;
		ps_req.valid <= 1'b0;
		@(posedge clk);
	endtask
	task automatic data_op(input logic wr, input logic wd, input agu_pkg::ind_mode_t m,
		input logic [3:0] s, input logic [15:0] p, input logic [15:0] o, input logic mo,
		input logic [15:0] me);
		logic q;
		logic [15:0] e;
		q = cfg[11:8] != 4'hF && brc[15] && s == cfg[11:8] && wr && wd && (^m);
		e = mo ? me : m[0] ? p + o : p;
		if (q) e = rv(rv(p & 16'hFFFE) + rv({brc[14:0], 1'b0})) & 16'hFFFE;
		q_dat.push_back({q, e});
		last_ea = e;
		data_req <= '{1'b1, wr, wd, m, s, p, o, mo, me};
		@(posedge clk);
	endtask
	task automatic ps_op(input agu_pkg::ps_kind_t k, input logic h, input logic w,
		input logic [22:0] pc, input logic [15:0] ea, input logic [15:0] wd);
		logic [23:0] a, d;
		logic [2:0] ln;
		logic t;
		t = k == agu_pkg::PS_TABLE_RD || k == agu_pkg::PS_TABLE_WR;
		a = k == agu_pkg::PS_FETCH ? {1'b0, pc[22:1], 1'b0} : {pg, ea[15:1], 1'b0};
		ln = k == agu_pkg::PS_FETCH ? 3'b111 : h ? ((w || !ea[0]) ? 3'b100 : 3'b000)
			: w || !t ? 3'b011 : {1'b0, ea[0], ~ea[0]};
		q_cmd.push_back({k != agu_pkg::PS_TABLE_WR, k == agu_pkg::PS_TABLE_WR, t && pg[7], a, ln});
		d = {a[7:0], a[15:0]} ^ 24'h5A_C3E1;
		if (k == agu_pkg::PS_TABLE_RD || k == agu_pkg::PS_WINDOW_RD)
			q_ret.push_back(h ? ((w || !ea[0]) ? {8'h00, d[23:16]} : 16'h0000)
				: (w || !t) ? d[15:0] : {8'h00, ea[0] ? d[15:8] : d[7:0]});
		if (k == agu_pkg::PS_TABLE_WR)
			q_wd.push_back(h ? {wd[7:0], 16'h0000} : w ? {8'h00, wd}
				: {8'h00, wd[7:0], wd[7:0]});
		ps_req <= '{1'b1, k, h, w, pc, ea, wd};
		@(posedge clk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ****
	// result watcher
	// ****
	always @(posedge clk)
		rd_seen <= reg_rd;
	always @(negedge clk)
	begin
		e_reg = rd_seen ? q_reg.pop_front() : 16'h0000;
		`CHK("reg_rdata", e_reg, reg_rdata)
		if (data_ans.valid)
		begin
			e_dat = q_dat.pop_front();
			g_dat = {data_ans.bitrev, data_ans.ea};
			`CHK("data_ans", e_dat, g_dat)
		end
		if (ps_cmd.rd || ps_cmd.wr)
		begin
			e_cmd = q_cmd.pop_front();
			g_cmd = {ps_cmd.rd, ps_cmd.wr, ps_cmd.config_space, ps_cmd.addr, ps_cmd.lanes};
			`CHK("ps_cmd", e_cmd, g_cmd)
		end
		if (ps_cmd.wr)
		begin
			e_wd = q_wd.pop_front();
			`CHK("ps_wdata", e_wd, ps_cmd.wdata)
		end
		if (ps_rd_valid)
		begin
			e_ret = q_ret.pop_front();
			`CHK("ps_rd_data", e_ret, ps_rd_data)
		end
	end
	// ****
	// main sequence
	// ****
	initial
	begin
		cfg = `RST_MODCFG;
		brc = `RST_BITREV;
		pg = `RST_TABLE_PAGE;
		void'($urandom(60252));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		reg_op(0, `ADDR_MODCFG, 0, `RST_MODCFG);
		reg_op(0, `ADDR_BITREV, 0, `RST_BITREV);
		reg_op(0, `ADDR_TABLE_PAGE, 0, {8'h00, `RST_TABLE_PAGE});
		reg_op(0, `ADDR_LASTEA, 0, 16'h0000);
		reg_op(1, 4'h9, 16'hFFFF, 0);
		reg_op(1, `ADDR_LASTEA, 16'h1234, 0);
		reg_op(1, `ADDR_TABLE_PAGE, 16'hFFAB, 0);
		reg_op(0, 4'h9, 0, 16'h0000);
		reg_op(0, `ADDR_LASTEA, 0, 16'h0000);
		reg_op(0, `ADDR_TABLE_PAGE, 0, 16'h00AB);
		idle();
		for (int p = 0; p < 2; p++)
		begin
			ps_op(agu_pkg::PS_FETCH, 0, 1, 23'($urandom), 0, 0);
			ps_op(agu_pkg::PS_TABLE_RD, 1, 1, 0, 16'h0101, 0);
			ps_op(agu_pkg::PS_TABLE_RD, 1, 0, 0, 16'h0200, 0);
			ps_op(agu_pkg::PS_TABLE_RD, 1, 0, 0, 16'h0203, 0);
			ps_op(agu_pkg::PS_TABLE_RD, 0, 0, 0, 16'($urandom), 0);
			ps_op(agu_pkg::PS_TABLE_WR, 1, 0, 0, 16'h0305, 16'($urandom));
			ps_op(agu_pkg::PS_TABLE_RD, 0, 1, 0, 16'($urandom), 0);
			ps_op(agu_pkg::PS_TABLE_WR, 0, 0, 0, 16'($urandom), 16'($urandom));
			ps_op(agu_pkg::PS_TABLE_WR, 1, 1, 0, 16'h3456, 16'($urandom));
			ps_op(agu_pkg::PS_WINDOW_RD, 0, 1, 0, 16'($urandom), 0);
			idle();
			reg_op(1, `ADDR_TABLE_PAGE, 16'h0012, 0);
			idle();
		end
		reg_op(1, `ADDR_MODCFG, 16'h0500, 0);
		reg_op(1, `ADDR_BITREV, 16'h8008, 0);
		idle();
		pt = 16'h1000;
		for (int k = 1; k <= 16; k++)
		begin
			data_op(1, 1, k[1] ? agu_pkg::MODE_PRE_INC : agu_pkg::MODE_POST_INC, 4'h5, pt,
				16'h0002, k[0], 16'h2222);
			pt = 16'h1000 | {11'h000, k[0], k[1], k[2], k[3], 1'b0};
		end
		idle();
		for (int c = 0; c < 3; c++)
		begin
			reg_op(1, `ADDR_MODCFG, {4'h0, c == 1 ? 4'hF : 4'h3, 8'h00}, 0);
			reg_op(1, `ADDR_BITREV, {c != 2, 15'($urandom)}, 0);
			reg_op(0, `ADDR_BITREV, 0, brc);
			idle();
			repeat (60)
				data_op($urandom_range(3) != 0, $urandom_range(3) != 0,
					agu_pkg::ind_mode_t'($urandom_range(3)),
					$urandom_range(1) ? cfg[11:8] : 4'($urandom), 16'($urandom),
					16'($urandom), 1'($urandom), 16'($urandom));
			idle();
		end
		reg_op(0, `ADDR_LASTEA, 0, last_ea);
		idle();
		for (int i = 0; i < 20
			&& q_reg.size() + q_dat.size() + q_cmd.size() + q_ret.size() + q_wd.size() > 0; i++)
			@(posedge clk);
		if (q_reg.size() + q_dat.size() + q_cmd.size() + q_ret.size() + q_wd.size() > 0)
			err_total++;
		tally_and_finish();
	end
endmodule
